// ---- core/dchm_channel.sv ----
// How it works
// [R01] Upper select bits route ready indicators to pins
// [R02] Pin three source chosen by bits three-two
// [R03] Pin two may carry channel A clocks
// [R04] Pin two codes: latch, tx16, tx1, rx1
// [R05] Pins zero/one become active-low RTS when enabled
// [R06] Latch-driven pin shows complement of latch bit
// [R07] Idle transmitter holds serial output high
// [R08] One low start bit before each character
// [R09] Data bits go out LSB first
// [R10] Optional parity bit after MSB, before stop
// [R11] One-entry holding stage feeds tx shifter
// [R12] Masked interrupt when holding and shifter empty
// [R13] Disable drains queued characters before idling
// [R14] No holding writes accepted after disable
// [R15] Received characters move into three-entry FIFO
// [R16] Data read pops oldest FIFO character
// [R17] Receiver inactive while serial input high
// [R18] Start bit valid only if low at 7th sample
// [R19] Later bits sampled once per bit period
// [R20] Oversampling repeats for every start bit
// [R21] Check parity, sample stop, then re-arm
// [R22] Flag framing, parity and overrun errors
// [R23] Per-direction bit clock source select
// [R24] Stop bit high for configured stop length
`timescale 1ns/1ps
`include "dchm_defines.svh"
module dchm_channel (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // 16x tick sources from the timing block
  input wire logic i_brg_tick,
  input wire logic i_ct_tick,
  input wire logic i_ext_tx_tick,
  input wire logic i_ext_rx_tick,
  // Serial lines
  input wire logic i_serial_in,
  output logic o_serial_out,
  // Channel B and timer sources for the pin mux
  input wire logic i_request_to_send_b_n,
  input wire logic i_chan_b_rts_en,
  input wire logic i_transmit_ready_b,
  input wire logic i_receive_ready_or_full_b,
  input wire logic i_chan_b_tx_clock_1x,
  input wire logic i_chan_b_rx_clock_1x,
  input wire logic i_ct_ready,
  // Output port pins and transmit interrupt
  output logic [7:0] o_out_pins,
  output logic o_tx_irq
);
  import dchm_pkg::*;

  // ----------------------------------------
  // State and working signals
  // ----------------------------------------
  dchm_state_t s_q; // Registered state
  dchm_state_t s_d; // Next state
  logic tx_tick; // Selected tx 16x tick
  logic rx_tick; // Selected rx 16x tick

  // Clock source selection per direction [R23]
  assign tx_tick = s_q.clksel[3] ? i_ext_tx_tick :
                   (s_q.clksel[2] ? i_ct_tick : i_brg_tick);
  assign rx_tick = s_q.clksel[1] ? i_ext_rx_tick :
                   (s_q.clksel[0] ? i_ct_tick : i_brg_tick);

  // Outputs straight from flops
  assign o_readdata = {24'h00_0000, s_q.rdata};
  assign o_waitrequest = s_q.waitreq;
  assign o_serial_out = s_q.ser_out;
  assign o_out_pins = s_q.pins;
  assign o_tx_irq = s_q.tx_irq;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic acc; // Request accepted this edge
    logic wr; // Accepted write on low byte
    logic [7:0] wd; // Write byte
    logic [7:0] mask; // Character width mask
    logic [2:0] last; // Index of the MSB
    logic par_on; // Parity bit present
    logic par_bit; // Expected parity bit
    logic pop; // FIFO pop
    logic push; // FIFO push
    logic [7:0] ch; // Assembled character
    logic [1:0] cnt; // FIFO count after pop
    logic rts_a; // Channel A RTS asserted
    s_d = s_q;
    acc = (i_read | i_write) & ~s_q.waitreq;
    wr = acc & i_write & i_byteenable[0];
    wd = i_writedata[7:0];
    mask = 8'hFF >> (2'h3 - s_q.mode1[1:0]);
    last = {1'b1, s_q.mode1[1:0]};
    par_on = s_q.mode1[4:3] != `DCHM_PAR_NONE;
    par_bit = s_q.mode1[3] ? s_q.mode1[2] : (^(s_q.tx_shift & mask) ^ s_q.mode1[2]);
    pop = 1'b0;
    push = 1'b0;
    ch = s_q.rx_shift >> (2'h3 - s_q.mode1[1:0]);
    cnt = s_q.fifo_cnt;
    rts_a = (s_q.mode1[`DCHM_M1_RXRTS] & (s_q.fifo_cnt != `DCHM_FIFO_DEPTH)) |
            (s_q.mode2[`DCHM_M2_TXRTS] & (s_q.tx_hold_full | ~s_q.tx_st[0]));
    // One wait cycle, then the answer
    s_d.waitreq = ~((i_read | i_write) & s_q.waitreq);
    if ((i_read | i_write) & s_q.waitreq) begin
      s_d.rd_pop = 1'b0;
      unique case (i_address)
        `DCHM_OFF_MODE1: s_d.rdata = s_q.mode1;
        `DCHM_OFF_MODE2: s_d.rdata = s_q.mode2;
        `DCHM_OFF_STATUS: s_d.rdata = {1'b0, s_q.err_frm, s_q.err_par, s_q.err_ovr,
            ~s_q.tx_hold_full & s_q.tx_st[0], ~s_q.tx_hold_full & s_q.tx_en,
            s_q.fifo_cnt == `DCHM_FIFO_DEPTH, s_q.fifo_cnt != 2'h0};
        `DCHM_OFF_DATA: begin
          // Head of FIFO, popped on the answer edge
          s_d.rdata = s_q.fifo[0];
          s_d.rd_pop = s_q.fifo_cnt != 2'h0;
        end
        `DCHM_OFF_CLKSEL: s_d.rdata = {4'h0, s_q.clksel};
        `DCHM_OFF_IMASK: s_d.rdata = s_q.imask;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (wr) begin
      unique case (i_address)
        `DCHM_OFF_MODE1: s_d.mode1 = wd;
        `DCHM_OFF_MODE2: s_d.mode2 = wd;
        `DCHM_OFF_CLKSEL: s_d.clksel = wd[3:0];
        `DCHM_OFF_OUTSET: s_d.latch = s_q.latch | wd;
        `DCHM_OFF_OUTCLR: s_d.latch = s_q.latch & ~wd;
        `DCHM_OFF_OPSEL: s_d.opsel = wd;
        `DCHM_OFF_IMASK: s_d.imask = wd;
        `DCHM_OFF_DATA: begin
          // Holding stage takes a byte only while enabled and empty
          if (s_q.tx_en && !s_q.tx_hold_full) begin // [R11] [R14]
            s_d.tx_hold = wd & mask;
            s_d.tx_hold_full = 1'b1;
          end
        end
        `DCHM_OFF_CMD: begin
          if (wd[`DCHM_CMD_TXEN]) s_d.tx_en = 1'b1;
          if (wd[`DCHM_CMD_TXDIS]) s_d.tx_en = 1'b0; // [R14]
          if (wd[`DCHM_CMD_RXEN]) s_d.rx_en = 1'b1;
          if (wd[`DCHM_CMD_RXDIS]) s_d.rx_en = 1'b0;
          if (wd[`DCHM_CMD_ERRCLR]) begin
            s_d.err_ovr = 1'b0;
            s_d.err_par = 1'b0;
            s_d.err_frm = 1'b0;
          end
        end
        default: ;
      endcase
    end
    pop = acc & i_read & s_q.rd_pop & (i_address == `DCHM_OFF_DATA); // [R16]

    // Transmitter; keeps draining after disable [R13]
    if (tx_tick) begin
      s_d.tx_clk16 = ~s_q.tx_clk16;
      s_d.tx_cnt = s_q.tx_cnt + 4'h1;
    end
    unique case (s_q.tx_st)
      TX_IDLE: begin
        s_d.ser_out = 1'b1; // [R07]
        s_d.tx_cnt = 4'h0;
        if (s_q.tx_hold_full) begin
          // Holding stage moves to the shifter [R11]
          s_d.tx_shift = s_q.tx_hold;
          s_d.tx_hold_full = 1'b0;
          s_d.tx_st = TX_START;
          s_d.ser_out = 1'b0; // [R08]
        end
      end
      TX_START: begin
        if (tx_tick && s_q.tx_cnt == `DCHM_TICKS_BIT) begin
          s_d.tx_st = TX_DATA;
          s_d.tx_bit = 3'h0;
          s_d.tx_par = par_bit;
          s_d.ser_out = s_q.tx_shift[0]; // [R09]
        end
      end
      TX_DATA: begin
        if (tx_tick && s_q.tx_cnt == `DCHM_TICKS_BIT) begin
          s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
          s_d.tx_bit = s_q.tx_bit + 3'h1;
          s_d.ser_out = s_q.tx_shift[1];
          if (s_q.tx_bit == last) begin
            s_d.tx_st = par_on ? TX_PAR : TX_STOP; // [R10]
            s_d.ser_out = par_on ? s_q.tx_par : 1'b1;
            s_d.tx_stop2 = s_q.mode2[`DCHM_M2_STOP2];
          end
        end
      end
      TX_PAR: begin
        if (tx_tick && s_q.tx_cnt == `DCHM_TICKS_BIT) begin
          s_d.tx_st = TX_STOP;
          s_d.ser_out = 1'b1; // [R24]
        end
      end
      TX_STOP: begin
        if (tx_tick && s_q.tx_cnt == `DCHM_TICKS_BIT) begin
          s_d.tx_stop2 = 1'b0;
          if (!s_q.tx_stop2) begin
            // Stop length done; next start or idle [R24]
            s_d.tx_st = TX_IDLE;
            if (s_q.tx_hold_full) begin
              s_d.tx_shift = s_q.tx_hold;
              s_d.tx_hold_full = 1'b0;
              s_d.tx_st = TX_START;
              s_d.ser_out = 1'b0; // [R08]
            end
          end
        end
      end
    endcase

    // Receiver
    if (rx_tick) begin
      s_d.rx_cnt = s_q.rx_cnt + 4'h1;
    end
    unique case (s_q.rx_st)
      RX_IDLE: begin
        // Quiet line does nothing; a falling edge arms the check [R17] [R20]
        s_d.rx_cnt = 4'h0;
        if (s_q.rx_en && s_q.rx_prev && !i_serial_in) begin
          s_d.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick && s_q.rx_cnt == `DCHM_START_SMP) begin
          // Seventh sample decides start or noise [R18]
          s_d.rx_cnt = 4'h0;
          s_d.rx_bit = 3'h0;
          s_d.rx_par_bad = 1'b0;
          s_d.rx_st = i_serial_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_tick && s_q.rx_cnt == `DCHM_TICKS_BIT) begin
          // Mid-bit sample once per bit period [R19]
          s_d.rx_shift = {i_serial_in, s_q.rx_shift[7:1]};
          s_d.rx_bit = s_q.rx_bit + 3'h1;
          if (s_q.rx_bit == last) begin
            s_d.rx_st = par_on ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick && s_q.rx_cnt == `DCHM_TICKS_BIT) begin
          // Compare against the expected parity [R21]
          s_d.rx_par_bad = i_serial_in != (s_q.mode1[3] ? s_q.mode1[2] :
                           (^(ch & mask) ^ s_q.mode1[2]));
          s_d.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick && s_q.rx_cnt == `DCHM_TICKS_BIT) begin
          // Stop sample ends the frame, then re-arm [R21]
          push = 1'b1;
          s_d.rx_st = RX_IDLE;
          if (!i_serial_in) s_d.err_frm = 1'b1; // [R22]
          if (s_q.rx_par_bad) s_d.err_par = 1'b1; // [R22]
        end
      end
    endcase
    s_d.rx_prev = i_serial_in;

    // Three-entry FIFO, head at index zero [R15]
    if (pop) begin
      s_d.fifo = {8'h00, s_q.fifo[2:1]};
      cnt = s_q.fifo_cnt - 2'h1;
    end
    if (push) begin
      if (cnt == `DCHM_FIFO_DEPTH) begin
        // Full: newest entry overwritten [R22]
        s_d.fifo[2] = ch & mask;
        s_d.err_ovr = 1'b1;
      end else begin
        s_d.fifo[cnt] = ch & mask; // [R15]
        cnt = cnt + 2'h1;
      end
    end
    s_d.fifo_cnt = cnt;

    // Output pin mux
    s_d.pins = ~s_q.latch; // [R06]
    if (s_q.mode1[`DCHM_M1_RXRTS] | s_q.mode2[`DCHM_M2_TXRTS]) begin
      s_d.pins[0] = ~rts_a; // [R05]
    end
    if (i_chan_b_rts_en) s_d.pins[1] = i_request_to_send_b_n; // [R05]
    unique case (s_q.opsel[1:0])
      2'h1: s_d.pins[2] = s_q.tx_clk16; // [R03] [R04]
      2'h2: s_d.pins[2] = s_q.tx_cnt[3]; // [R04]
      2'h3: s_d.pins[2] = s_q.rx_cnt[3]; // [R04]
      default: ;
    endcase
    unique case (s_q.opsel[3:2])
      2'h1: s_d.pins[3] = i_ct_ready; // [R02]
      2'h2: s_d.pins[3] = i_chan_b_tx_clock_1x; // [R02]
      2'h3: s_d.pins[3] = i_chan_b_rx_clock_1x; // [R02]
      default: ;
    endcase
    // Indicators pull their pin low when active [R01]
    if (s_q.opsel[4]) begin
      s_d.pins[4] = ~(s_q.mode1[`DCHM_M1_RXISEL] ?
                      (s_q.fifo_cnt == `DCHM_FIFO_DEPTH) : (s_q.fifo_cnt != 2'h0));
    end
    if (s_q.opsel[5]) s_d.pins[5] = ~i_receive_ready_or_full_b;
    if (s_q.opsel[6]) s_d.pins[6] = ~(s_q.tx_en & ~s_q.tx_hold_full);
    if (s_q.opsel[7]) s_d.pins[7] = ~i_transmit_ready_b;

    // Transmitter-empty request [R12]
    s_d.tx_irq = s_q.imask[`DCHM_IM_TXA] & ~s_q.tx_hold_full & s_q.tx_st[0];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.tx_st <= TX_IDLE;
      s_q.rx_st <= RX_IDLE;
      s_q.ser_out <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.waitreq <= 1'b1;
      s_q.pins <= 8'hFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic wr_hold_ok; // Accepted data write while able to take it
  logic wr_hold_dis; // Data write while disabled and empty
  assign wr_hold_ok = i_write && !s_q.waitreq && i_byteenable[0] &&
      i_address == `DCHM_OFF_DATA && s_q.tx_en && !s_q.tx_hold_full;
  assign wr_hold_dis = i_write && !s_q.waitreq && i_address == `DCHM_OFF_DATA &&
      !s_q.tx_en && !s_q.tx_hold_full;

  a_idle_line_high: assert property ( // [R07]
    s_q.tx_st == TX_IDLE && !$past(s_q.tx_hold_full) |-> o_serial_out)
    else $error("serial out low while idle");
  a_start_bit_low: assert property ( // [R08]
    s_q.tx_st == TX_START |-> !o_serial_out)
    else $error("start bit not low");
  a_lsb_first_out: assert property ( // [R09]
    s_q.tx_st == TX_START && tx_tick && s_q.tx_cnt == 4'hF
    |=> s_q.tx_st == TX_DATA && o_serial_out == $past(s_q.tx_shift[0]))
    else $error("first data bit is not the LSB");
  a_parity_slot: assert property ( // [R10]
    s_q.tx_st == TX_PAR |-> s_q.mode1[4:3] != 2'h2 && o_serial_out == s_q.tx_par)
    else $error("parity slot wrong");
  a_hold_loads: assert property ( // [R11]
    wr_hold_ok |=> s_q.tx_hold_full || s_q.tx_st == TX_START)
    else $error("holding write lost");
  a_tx_irq_empty: assert property ( // [R12]
    s_q.imask[0] && !s_q.tx_hold_full && s_q.tx_st == TX_IDLE |=> o_tx_irq)
    else $error("transmit interrupt missing");
  a_no_write_dis: assert property ( // [R14]
    wr_hold_dis |=> !s_q.tx_hold_full)
    else $error("write accepted while disabled");
  a_fifo_push: assert property ( // [R15]
    s_q.rx_st == RX_STOP && rx_tick && s_q.rx_cnt == 4'hF && s_q.fifo_cnt == 2'h0
    |=> s_q.fifo_cnt == 2'h1)
    else $error("received character not queued");
  a_start_noise: assert property ( // [R18]
    s_q.rx_st == RX_START && rx_tick && s_q.rx_cnt == 4'h6 && i_serial_in
    |=> s_q.rx_st == RX_IDLE)
    else $error("noise taken as start");
  a_latch_pins: assert property ( // [R06]
    s_q.opsel[7:4] == 4'h0 |=> o_out_pins[7:4] == ~$past(s_q.latch[7:4]))
    else $error("latch pin not complemented");

  c_tx_frame: cover property (s_q.tx_st == TX_STOP ##1 s_q.tx_st == TX_IDLE);
  c_rx_good: cover property (s_q.rx_st == RX_STOP ##1 s_q.fifo_cnt != 2'h0);
  c_fifo_full: cover property (s_q.fifo_cnt == 2'h3);
  c_overrun: cover property ($rose(s_q.err_ovr));
endmodule : dchm_channel

// ---- core/dchm_defines.svh ----
`ifndef DCHM_DEFINES_SVH
`define DCHM_DEFINES_SVH
// Register byte offsets on the Avalon-MM slave
`define DCHM_OFF_MODE1   6'h00
`define DCHM_OFF_MODE2   6'h04
`define DCHM_OFF_STATUS  6'h08
`define DCHM_OFF_CMD     6'h0C
`define DCHM_OFF_DATA    6'h10
`define DCHM_OFF_CLKSEL  6'h14
`define DCHM_OFF_OUTSET  6'h18
`define DCHM_OFF_OUTCLR  6'h1C
`define DCHM_OFF_OPSEL   6'h20
`define DCHM_OFF_IMASK   6'h24
// Field positions
`define DCHM_M1_RXRTS    7
`define DCHM_M1_RXISEL   6
`define DCHM_M2_TXRTS    5
`define DCHM_M2_STOP2    0
`define DCHM_IM_TXA      0
`define DCHM_CMD_TXEN    0
`define DCHM_CMD_TXDIS   1
`define DCHM_CMD_RXEN    2
`define DCHM_CMD_RXDIS   3
`define DCHM_CMD_ERRCLR  4
// Parity mode codes
`define DCHM_PAR_NONE    2'h2
// Reset values
`define DCHM_RST_BYTE    8'h00
// Timing counts, in 16x ticks, and FIFO depth in entries
`define DCHM_TICKS_BIT   4'hF
`define DCHM_START_SMP   4'h6
`define DCHM_FIFO_DEPTH  2'h3
`endif

// ---- core/dchm_pkg.sv ----
package dchm_pkg;
  // Transmitter states, one-hot
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } dchm_tx_st_t;
  // Receiver states, one-hot
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } dchm_rx_st_t;
  // Whole state of the channel
  typedef struct packed {
    dchm_tx_st_t tx_st;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_stop2;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    logic tx_en;
    logic tx_clk16;
    logic ser_out;
    dchm_rx_st_t rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par_bad;
    logic rx_prev;
    logic rx_en;
    logic [2:0][7:0] fifo;
    logic [1:0] fifo_cnt;
    logic err_ovr;
    logic err_par;
    logic err_frm;
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [3:0] clksel;
    logic [7:0] imask;
    logic [7:0] latch;
    logic [7:0] opsel;
    logic waitreq;
    logic rd_pop;
    logic [7:0] rdata;
    logic [7:0] pins;
    logic tx_irq;
  } dchm_state_t;
endpackage : dchm_pkg

// ---- bench/dchm_remote.sv ----
`timescale 1ns/1ps
// ---------------------------------------
// Far-end serial transmitter and receiver
// ---------------------------------------
module dchm_remote (
  // Clock and 16x tick
  input wire logic i_ref_clk,
  input wire logic i_tick,
  // Line from the channel, line to it
  input wire logic i_line_in,
  output logic o_line_out
);
  logic [8:0] got; // Last frame heard, bit 8 is parity or stop
  int got_n = 0; // Frames heard
  initial o_line_out = 1'b1; // Idle mark
  // Wait for n ticks
  task automatic ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge i_ref_clk);
      if (i_tick) k++;
    end
  endtask : ticks
  // Drive a level for n ticks
  task automatic hold(input logic v, input int n);
    o_line_out <= v;
    ticks(n);
  endtask : hold
  // One frame: par 0 none, 1 even, 2 wrong; stp is the stop level
  task automatic send(input logic [7:0] d, input int par, input logic stp);
    hold(1'b0, 16); // Start bit
    for (int i = 0; i < 8; i++) hold(d[i], 16); // LSB first
    if (par != 0) hold(^d ^ (par == 2), 16); // Parity
    hold(stp, 16); // Stop bit
    hold(1'b1, 16); // Idle gap
  endtask : send
  // Decoder of the channel output, sampled mid-bit
  always begin
    @(negedge i_line_in);
    ticks(8);
    if (i_line_in == 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        ticks(16);
        got[i] = i_line_in;
      end
      got_n++;
    end
  end
endmodule : dchm_remote

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "dchm_defines.svh"
module testbench;
  // --------------
  // Signals
  // --------------
  logic i_ref_clk = 1'b0;
  logic i_sys_rst;
  logic [5:0] i_address;
  logic i_read;
  logic i_write;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic i_brg_tick = 1'b0;
  logic i_serial_in;
  logic o_serial_out;
  logic [6:0] bin; // B rts_n, rts_en, txrdy, rxrdy, timer, txclk, rxclk
  logic [7:0] o_out_pins;
  logic o_tx_irq;
  logic [1:0] tick_cnt = 2'h0; // Tick divider
  int bad_count = 0;
  int checks = 0;
  int n0;
  int tog;
  logic p2;
  logic [7:0] rd; // Last read byte
  // Pin mux rows: select, latch, inputs, pins
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] lat;
    logic [6:0] bin;
    logic [7:0] pins;
  } dchm_row_t;
  dchm_row_t rows [8] = '{
    '{8'h00, 8'h5A, 7'h40, 8'hA5}, '{8'hF0, 8'h00, 7'h58, 8'h1F},
    '{8'hF0, 8'hFF, 7'h40, 8'hB0}, '{8'h04, 8'h08, 7'h44, 8'hFF},
    '{8'h04, 8'h00, 7'h40, 8'hF7}, '{8'h08, 8'h00, 7'h41, 8'hF7},
    '{8'h08, 8'h08, 7'h42, 8'hFF}, '{8'h0C, 8'h00, 7'h42, 8'hF7}
  };
  logic [7:0] txb [3] = '{8'h5D, 8'h80, 8'h01};
  // --------------
  // Instances
  // --------------
  dchm_channel dut_u (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_byteenable(4'h1),
    .i_writedata(i_writedata),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .i_brg_tick(i_brg_tick),
    .i_ct_tick(1'b0),
    .i_ext_tx_tick(1'b0),
    .i_ext_rx_tick(1'b0),
    .i_serial_in(i_serial_in),
    .o_serial_out(o_serial_out),
    .i_request_to_send_b_n(bin[6]),
    .i_chan_b_rts_en(bin[5]),
    .i_transmit_ready_b(bin[4]),
    .i_receive_ready_or_full_b(bin[3]),
    .i_chan_b_tx_clock_1x(bin[1]),
    .i_chan_b_rx_clock_1x(bin[0]),
    .i_ct_ready(bin[2]),
    .o_out_pins(o_out_pins),
    .o_tx_irq(o_tx_irq)
  );
  dchm_remote rem_u (
    .i_ref_clk(i_ref_clk),
    .i_tick(i_brg_tick),
    .i_line_in(o_serial_out),
    .o_line_out(i_serial_in)
  );
  // Clock and 16x tick every fourth cycle
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    i_brg_tick <= (tick_cnt == 2'h3);
  end
  // --------------
  // Tasks
  // --------------
  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= {24'h00_0000, d};
    @(posedge i_ref_clk);
    while (o_waitrequest !== 1'b0 && n < 50) begin
      @(posedge i_ref_clk);
      n++;
    end
    rd = o_readdata[7:0];
    i_write <= 1'b0;
    i_read <= 1'b0;
    repeat (2) @(posedge i_ref_clk); // Registered outputs fed by the write settle
    if (n == 50) begin
      chk(8'h00, 8'h01, "bus hang");
      final_report();
    end
  endtask : bus
  // Wait until the far end has heard n frames
  task automatic frames(input int n);
    int k;
    k = 0;
    while (rem_u.got_n < n && k < 3000) begin
      @(posedge i_ref_clk);
      k++;
    end
    if (k == 3000) begin
      chk(8'h00, 8'h01, "no frame");
      final_report();
    end
  endtask : frames
  // --------------
  // Sequence
  // --------------
  initial begin
    i_sys_rst = 1'b1;
    i_address = 6'h00;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0000_0000;
    bin = 7'h40;
    repeat (3) @(posedge i_ref_clk);
    chk(o_out_pins, 8'hFF, "reset pins");
    chk({6'h00, o_serial_out, o_tx_irq}, 8'h02, "reset line");
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    bus(1'b1, `DCHM_OFF_MODE1, 8'h13);
    bus(1'b1, `DCHM_OFF_CMD, 8'h05);
    bus(1'b1, `DCHM_OFF_IMASK, 8'h01);
    chk({7'h00, o_tx_irq}, 8'h01, "irq idle");
    bus(1'b0, `DCHM_OFF_OPSEL, 8'h00);
    chk(rd, 8'h00, "select reads");
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd, 8'h00, "unmapped");
    // Table of pin mux cases
    foreach (rows[i]) begin
      bus(1'b1, `DCHM_OFF_OUTCLR, 8'hFF);
      bus(1'b1, `DCHM_OFF_OUTSET, rows[i].lat);
      bin <= rows[i].bin;
      bus(1'b1, `DCHM_OFF_OPSEL, rows[i].sel);
      chk(o_out_pins, rows[i].pins, "pin mux");
    end
    // Pin two clock codes, with traffic both ways
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, `DCHM_OFF_OPSEL, 8'(c));
      tog = 0;
      n0 = rem_u.got_n;
      p2 = o_out_pins[2];
      fork
        bus(1'b1, `DCHM_OFF_DATA, txb[c-1]);
        rem_u.send(8'hC3 ^ 8'(c), 0, 1'b1);
        repeat (700) begin
          @(posedge i_ref_clk);
          if (o_out_pins[2] !== p2) tog++;
          p2 = o_out_pins[2];
        end
      join
      frames(n0 + 1);
      chk({7'h00, tog != 0}, 8'h01, "pin two clock");
      chk(rem_u.got[7:0], txb[c-1], "tx byte");
      chk({7'h00, rem_u.got[8]}, 8'h01, "tx stop");
      bus(1'b0, `DCHM_OFF_DATA, 8'h00);
      chk(rd, 8'hC3 ^ 8'(c), "rx byte");
    end
    // Request-to-send, drain on disable, refused write
    bus(1'b1, `DCHM_OFF_OUTCLR, 8'hFF);
    bus(1'b1, `DCHM_OFF_OUTSET, 8'h01);
    bin <= 7'h20;
    bus(1'b1, `DCHM_OFF_MODE2, 8'h20);
    chk({6'h00, o_out_pins[1:0]}, 8'h01, "rts idle");
    n0 = rem_u.got_n;
    bus(1'b1, `DCHM_OFF_DATA, 8'hA1);
    bus(1'b1, `DCHM_OFF_DATA, 8'hB2);
    bus(1'b1, `DCHM_OFF_CMD, 8'h02);
    chk({6'h00, o_out_pins[1:0]}, 8'h00, "rts busy");
    chk({7'h00, o_tx_irq}, 8'h00, "irq busy");
    frames(n0 + 1);
    repeat (64) @(posedge i_ref_clk); // Second byte leaves the holding stage
    bus(1'b1, `DCHM_OFF_DATA, 8'hC3);
    frames(n0 + 2);
    repeat (1500) @(posedge i_ref_clk);
    chk(8'(rem_u.got_n - n0), 8'h02, "frames sent");
    chk(rem_u.got[7:0], 8'hB2, "drained");
    chk({7'h00, o_tx_irq}, 8'h01, "irq empty");
    // Noise pulse, then a real start bit
    rem_u.hold(1'b0, 4);
    rem_u.hold(1'b1, 40);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h01, 8'h00, "noise");
    rem_u.send(8'h3C, 0, 1'b1);
    bus(1'b0, `DCHM_OFF_DATA, 8'h00);
    chk(rd, 8'h3C, "after noise");
    // Receiver on the stalled external tick hears nothing
    bus(1'b1, `DCHM_OFF_CLKSEL, 8'h02);
    rem_u.send(8'h5A, 0, 1'b1);
    bus(1'b1, `DCHM_OFF_CLKSEL, 8'h00);
    repeat (40) @(posedge i_ref_clk);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h01, 8'h00, "rx clock select");
    // Overrun: fourth character replaces the newest entry
    foreach (txb[i]) rem_u.send(8'h11 * 8'(i + 1), 0, 1'b1);
    rem_u.send(8'h44, 0, 1'b1);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h13, 8'h13, "overrun");
    foreach (txb[i]) begin
      bus(1'b0, `DCHM_OFF_DATA, 8'h00);
      chk(rd, (i == 2) ? 8'h44 : 8'h11 * 8'(i + 1), "fifo order");
    end
    bus(1'b1, `DCHM_OFF_CMD, 8'h10);
    // Framing error on a low stop sample
    rem_u.send(8'h55, 0, 1'b0);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h50, 8'h40, "framing");
    bus(1'b0, `DCHM_OFF_DATA, 8'h00);
    bus(1'b1, `DCHM_OFF_CMD, 8'h10);
    // Even parity both ways
    bus(1'b1, `DCHM_OFF_MODE1, 8'h03);
    bus(1'b1, `DCHM_OFF_CMD, 8'h05);
    n0 = rem_u.got_n;
    bus(1'b1, `DCHM_OFF_DATA, 8'h03);
    frames(n0 + 1);
    chk({7'h00, rem_u.got[8]}, 8'h00, "tx parity");
    rem_u.send(8'h0F, 1, 1'b1);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h21, 8'h01, "good parity");
    bus(1'b0, `DCHM_OFF_DATA, 8'h00);
    rem_u.send(8'h0F, 2, 1'b1);
    bus(1'b0, `DCHM_OFF_STATUS, 8'h00);
    chk(rd & 8'h20, 8'h20, "bad parity");
    final_report();
  end
endmodule : testbench
